// file: core/biw_packet_builder.v
`timescale 1ns/1ps
`include "biw_consts.vh"

// Functional notes
// [R1] first block_info_word of each phase is kept internally, never sent to host
// [R2] with send_time_words_enable set, date, time and zone words are sent
// [R3] with the enable set, errored words are sent marked errored, any format
// [R4] vector and message words tied to a system message word are not decoded
// [R5] error flag when more than two bit errors or check fails after correction
// [R6] phase field codes A, B, C, D as 0, 1, 2, 3
// [R7] host ignores unused packet bits; they may hold any value
// [R8] format field holds only 001, 010 or 101 when error flag is clear
// [R9] byte 3 zero, byte 2 error/phase/format, bytes 1-0 fourteen information bits
// [R10] date word: month bits 13-10, day 9-5, year 4-0
// [R11] month codes January..December as 0001..1100
// [R12] day codes days 1..31 starting at 00001
// [R13] time word: coarse seconds 13-11, minutes 10-5, hours 4-0
// [R14] zone word: accurate seconds, unused bit, dst flag, zone, subtype
// [R15] system message sent only for subtype 0100 or 0101
// [R16] transmitter sends a time word in every phase of frame 0 cycle 0
// [R17] with the enable clear no block_info_word packets are generated
// [R18] year counts modulo 32 starting at 1994
// [R19] coarse seconds count 7.5 s steps, 0 to 52.5 s
// [R20] minutes code 0..59
// [R21] hours code 0..23
module biw_packet_builder (
  input  wire        i_mclk,          // 40 mhz clock
  input  wire        i_rst_n,         // synchronous reset, active low
  input  wire        i_frame_start,   // pulse at each new frame
  input  wire        i_word_valid,    // pulse: one block_info_word received
  input  wire [1:0]  i_word_phase,    // phase of that word, 0 = A
  input  wire [2:0]  i_word_fmt,      // word format field
  input  wire [13:0] i_word_info,     // information bits
  input  wire [2:0]  i_word_err_cnt,  // bit errors found, saturating
  input  wire        i_word_chk_fail, // check character failed
  output reg         o_pkt_valid,     // packet waiting for the host
  output reg  [31:0] o_pkt_data,      // four packet bytes, byte 3 on top
  input  wire        i_pkt_ready,     // host takes the packet
  input  wire        s_axi_awvalid,   // write address valid
  output reg         s_axi_awready,   // write address ready
  input  wire [5:0]  s_axi_awaddr,    // write byte address
  input  wire        s_axi_wvalid,    // write data valid
  output reg         s_axi_wready,    // write data ready
  input  wire [31:0] s_axi_wdata,     // write data
  input  wire [3:0]  s_axi_wstrb,     // write byte enables
  output reg         s_axi_bvalid,    // write response valid
  input  wire        s_axi_bready,    // write response ready
  output reg  [1:0]  s_axi_bresp,     // write response
  input  wire        s_axi_arvalid,   // read address valid
  output reg         s_axi_arready,   // read address ready
  input  wire [5:0]  s_axi_araddr,    // read byte address
  output reg         s_axi_rvalid,    // read data valid
  input  wire        s_axi_rready,    // read data ready
  output reg  [31:0] s_axi_rdata,     // read data
  output reg  [1:0]  s_axi_rresp      // read response
);

  // fields and flags from the word decoder
  wire        dec_err;
  wire        dec_sendable;
  wire        dec_is_date;
  wire        dec_is_hms;
  wire        dec_is_zone;
  wire        dec_range_ok;
  wire [3:0]  dec_month;
  wire [4:0]  dec_day;
  wire [4:0]  dec_year;
  wire [2:0]  dec_csec;
  wire [5:0]  dec_minute;
  wire [4:0]  dec_hour;
  wire [2:0]  dec_asec;
  wire        dec_dst;
  wire [4:0]  dec_zone;
  wire [3:0]  dec_subtype;

  // state kept across words and the held halves of a bus write
  reg         send_en_r;
  reg         ovf_r;
  reg         range_ok_r;
  reg  [7:0]  sent_cnt_r;
  reg  [3:0]  seen_r;
  reg  [31:0] date_r;
  reg  [31:0] time_r;
  reg  [31:0] zone_r;
  reg  [31:0] last_pkt_r;
  reg         aw_held_r;
  reg  [5:0]  aw_addr_r;
  reg         w_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;

  // per-word decisions and bus strobes
  wire [3:0]  seen_nxt;
  wire        first_word;
  wire        forward;
  wire        slot_free;
  wire [31:0] pkt_nxt;
  wire        do_write;
  wire        ovf_clr;
  wire [2:0]  fmt_out;

  biw_field_decode u_decode (
    .i_info       (i_word_info),
    .i_fmt        (i_word_fmt),
    .i_err_cnt    (i_word_err_cnt),
    .i_check_fail (i_word_chk_fail),
    .o_err        (dec_err),
    .o_sendable   (dec_sendable),
    .o_is_date    (dec_is_date),
    .o_is_hms     (dec_is_hms),
    .o_is_zone    (dec_is_zone),
    .o_range_ok   (dec_range_ok),
    .o_month      (dec_month),
    .o_day        (dec_day),
    .o_year       (dec_year),
    .o_csec       (dec_csec),
    .o_minute     (dec_minute),
    .o_hour       (dec_hour),
    .o_asec       (dec_asec),
    .o_dst        (dec_dst),
    .o_zone       (dec_zone),
    .o_subtype    (dec_subtype)
  );

  // one seen flag per phase; a new frame re-arms all four
  // phases unused at the lower data rates simply stay unseen
  genvar ph;
  generate
    for (ph = 0; ph < 4; ph = ph + 1) begin : g_phase
      assign seen_nxt[ph] = i_frame_start ? 1'b0 :
                            (seen_r[ph] | (i_word_valid & (i_word_phase == ph)));
    end
  endgenerate

  // a frame start with a word in the same cycle clears the flags after the word is judged
  // the frame-structure word is consumed here and never offered
  assign first_word = ~seen_r[i_word_phase]; // [R1]

  // errored words pass whatever their format; clean ones only if they carry time.
  // the attached vector and message words are never looked at here
  assign forward = i_word_valid & send_en_r & ~first_word &
                   (dec_err | dec_sendable); // [R2] [R3] [R4] [R17] [R8]

  // a clean time word under the alternate code goes out as 010, so clean
  // packets only ever carry the three codes the host knows
  assign fmt_out = (dec_is_hms & ~dec_err) ? `FMT_HMS : i_word_fmt; // [R8] [R13]

  // unused bits are driven to zero, the host must not rely on it
  assign pkt_nxt = {`PKT_ID, dec_err, i_word_phase, 2'b00, fmt_out,
                    2'b00, i_word_info}; // [R9] [R6] [R7]

  // single packet slot; freed in the same cycle the host takes it
  // a host slower than the word rate loses words; the status flag shows it
  assign slot_free = ~o_pkt_valid | i_pkt_ready;

  // packet output stage; a word that finds the slot busy is dropped
  // a new packet may load in the very cycle the host takes the old one
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pkt_valid <= 1'b0;
      o_pkt_data  <= `WORD_RST;
      seen_r      <= 4'h0;
    end else begin
      seen_r <= seen_nxt; // [R1]
      if (forward && slot_free) begin
        o_pkt_valid <= 1'b1;
        o_pkt_data  <= pkt_nxt; // [R9]
      end else if (i_pkt_ready) begin
        o_pkt_valid <= 1'b0;
      end
    end
  end

  // decoded views of the last clean word of each kind, for software
  // the count wraps at 256 and includes words dropped for a busy slot
  // errored words update only the packet copy and the count, never the decoded views
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      date_r     <= `WORD_RST;
      time_r     <= `WORD_RST;
      zone_r     <= `WORD_RST;
      last_pkt_r <= `WORD_RST;
      range_ok_r <= 1'b1;
      sent_cnt_r <= 8'h00;
    end else if (forward) begin
      last_pkt_r <= pkt_nxt;
      sent_cnt_r <= sent_cnt_r + 8'h01;
      if (!dec_err) begin
        range_ok_r <= dec_range_ok;
        if (dec_is_date) begin
          date_r <= {18'h0_0000, dec_month, dec_day, dec_year}; // [R10] [R11] [R12] [R18]
        end
        if (dec_is_hms) begin
          time_r <= {18'h0_0000, dec_csec, dec_minute, dec_hour}; // [R13] [R19] [R20] [R21]
        end
        if (dec_is_zone) begin
          zone_r <= {18'h0_0000, dec_asec, 1'b0, dec_dst, dec_zone, dec_subtype}; // [R14]
        end
      end
    end
  end

  // write channel: address and data may come in either order
  // ready pulses last one cycle and are not repeated while a half is held
  // writes to the read-only views answer okay and change nothing
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign ovf_clr  = do_write & (aw_addr_r == `REG_STATUS_OFS) & w_strb_r[0] &
                    w_data_r[`STAT_OVF_BIT];

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 6'h00;
      w_held_r      <= 1'b0;
      w_data_r      <= `WORD_RST;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      send_en_r     <= `CTRL_RST;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `REG_CTRL_OFS: begin
            s_axi_bresp <= `RESP_OKAY;
            if (w_strb_r[0]) begin
              send_en_r <= w_data_r[`CTRL_SEND_BIT]; // [R2] [R17]
            end
          end
          `REG_STATUS_OFS, `REG_DATE_OFS, `REG_TIME_OFS,
          `REG_ZONE_OFS, `REG_LAST_PKT_OFS: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // overflow flag: a drop in the cycle of the clear keeps the flag set
  // software clears it by writing a one to its bit
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ovf_r <= 1'b0;
    end else if (forward && !slot_free) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // read channel: one read at a time, answer one cycle after the address
  // unmapped offsets read as zero with an error response
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `WORD_RST;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL_OFS:     s_axi_rdata <= {31'h0000_0000, send_en_r};
          `REG_STATUS_OFS:   s_axi_rdata <= {16'h0000, sent_cnt_r, 5'h00,
                                             range_ok_r, ovf_r, o_pkt_valid};
          `REG_DATE_OFS:     s_axi_rdata <= date_r;
          `REG_TIME_OFS:     s_axi_rdata <= time_r;
          `REG_ZONE_OFS:     s_axi_rdata <= zone_r;
          `REG_LAST_PKT_OFS: s_axi_rdata <= last_pkt_r;
          default: begin
            s_axi_rdata <= `WORD_RST;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // biw_packet_builder

// file: core/biw_consts.vh
`ifndef BIW_CONSTS_VH
`define BIW_CONSTS_VH

// register byte offsets on the axi4-lite slave
`define REG_CTRL_OFS       6'h00
`define REG_STATUS_OFS     6'h04
`define REG_DATE_OFS       6'h08
`define REG_TIME_OFS       6'h0C
`define REG_ZONE_OFS       6'h10
`define REG_LAST_PKT_OFS   6'h14

// field positions
`define CTRL_SEND_BIT      0
`define STAT_PEND_BIT      0
`define STAT_OVF_BIT       1
`define STAT_RANGE_BIT     2

// reset values
`define CTRL_RST           1'h0
`define WORD_RST           32'h0000_0000

// word format codes
`define FMT_DATE           3'h1
`define FMT_HMS            3'h2
`define FMT_HMS_ALT        3'h3
`define FMT_ZONE           3'h5
`define SUB_ZONE_A         4'h4
`define SUB_ZONE_B         4'h5

// packet framing
`define PKT_ID             8'h00
`define ERR_LIMIT          3'h2

// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// file: core/biw_field_decode.v
`timescale 1ns/1ps
`include "biw_consts.vh"

// splits one received word into its fields and decides if it may be sent
module biw_field_decode (
  input  wire [13:0] i_info,       // information bits 13..0
  input  wire [2:0]  i_fmt,        // word format field
  input  wire [2:0]  i_err_cnt,    // bit errors seen by the corrector
  input  wire        i_check_fail, // check character failed after correction
  output wire        o_err,        // packet error flag
  output wire        o_sendable,   // word carries time information
  output wire        o_is_date,    // month/day/year word
  output wire        o_is_hms,     // second/minute/hour word
  output wire        o_is_zone,    // accurate seconds / zone word
  output wire        o_range_ok,   // decoded fields lie in their legal ranges
  output wire [3:0]  o_month,      // month 1..12
  output wire [4:0]  o_day,        // day 1..31
  output wire [4:0]  o_year,       // year modulo 32 from 1994
  output wire [2:0]  o_csec,       // coarse seconds in 7.5 s steps
  output wire [5:0]  o_minute,     // minutes 0..59
  output wire [4:0]  o_hour,       // hours 0..23
  output wire [2:0]  o_asec,       // accurate seconds
  output wire        o_dst,        // daylight savings flag
  output wire [4:0]  o_zone,       // time zone code
  output wire [3:0]  o_subtype     // system message subtype
);

  // error flag: too many bit errors or failed check after correction
  assign o_err = (i_err_cnt > `ERR_LIMIT) | i_check_fail; // [R5]

  // the time word is accepted under both codes seen for it
  assign o_is_date = (i_fmt == `FMT_DATE);
  assign o_is_hms  = (i_fmt == `FMT_HMS) | (i_fmt == `FMT_HMS_ALT); // [R13]
  assign o_is_zone = (i_fmt == `FMT_ZONE);

  // date layout: month, day, year
  assign o_month = i_info[13:10]; // [R10] [R11]
  assign o_day   = i_info[9:5];   // [R12]
  assign o_year  = i_info[4:0];   // [R18]

  // time layout: coarse seconds, minute, hour
  assign o_csec   = i_info[13:11]; // [R19]
  assign o_minute = i_info[10:5];  // [R20]
  assign o_hour   = i_info[4:0];   // [R21]

  // zone layout; bit 10 is unused and ignored
  assign o_asec    = i_info[13:11]; // [R14]
  assign o_dst     = i_info[9];
  assign o_zone    = i_info[8:4];
  assign o_subtype = i_info[3:0];

  // other subtypes of a system message carry no time and are dropped
  assign o_sendable = o_is_date | o_is_hms |
                      (o_is_zone & ((o_subtype == `SUB_ZONE_A) |
                                    (o_subtype == `SUB_ZONE_B))); // [R15]

  // range check for software; the word is forwarded whatever the result
  assign o_range_ok = o_is_date ? ((o_month != 4'h0) & (o_month <= 4'hC) &
                                   (o_day != 5'h00)) :
                      o_is_hms  ? ((o_minute <= 6'h3B) & (o_hour <= 5'h17)) :
                      1'b1;

endmodule // biw_field_decode

// file: tb/biw_packet_builder_properties.sv
`timescale 1ns/1ps

// watches the packet port against the word input
module biw_packet_props (
  input wire        i_mclk,          // clock
  input wire        i_rst_n,         // sync reset, active low
  input wire        i_frame_start,   // new frame
  input wire        i_word_valid,    // word strobe
  input wire [1:0]  i_word_phase,    // word phase
  input wire [2:0]  i_word_fmt,      // word format
  input wire [13:0] i_word_info,     // information bits
  input wire [2:0]  i_word_err_cnt,  // bit errors
  input wire        i_word_chk_fail, // check failed
  input wire        o_pkt_valid,     // packet waiting
  input wire [31:0] o_pkt_data,      // packet bytes
  input wire        i_pkt_ready      // host takes packet
);
  reg  [3:0] seen_r; // phases whose first word has gone by
  wire       take_w; // word arrives while the slot is free
  wire        err_w;  // more than two bit errors or a failed check
  wire [16:0] body_w; // format and information bits the packet must carry

  assign take_w = i_word_valid && (!o_pkt_valid || i_pkt_ready);
  assign err_w  = (i_word_err_cnt > 3'h2) || i_word_chk_fail;
  // a clean time word under the alternate code must leave as 010
  assign body_w = {((!err_w && i_word_fmt == 3'h3) ? 3'h2 : i_word_fmt), i_word_info};

  // cleared after the same-cycle word is judged, as the design does
  always @(posedge i_mclk) begin
    if (!i_rst_n || i_frame_start) begin
      seen_r <= 4'h0;
    end else if (i_word_valid) begin
      seen_r[i_word_phase] <= 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_BYTE3_ZERO: assert property (o_pkt_valid |-> o_pkt_data[31:24] == 8'h00)
    else $error("packet id byte not zero");
  AST_PKT_HOLD: assert property (o_pkt_valid && !i_pkt_ready |=>
    o_pkt_valid && $stable(o_pkt_data)) else $error("packet lost before host took it");
  AST_ERR_FLAG: assert property (take_w ##1 o_pkt_valid |->
    o_pkt_data[23] == $past(err_w))
    else $error("error flag wrong");
  AST_PHASE: assert property (take_w ##1 o_pkt_valid |->
    o_pkt_data[22:21] == $past(i_word_phase)) else $error("phase field wrong");
  AST_BODY: assert property (take_w ##1 o_pkt_valid |->
    {o_pkt_data[18:16], o_pkt_data[13:0]} == $past(body_w))
    else $error("format or information bits wrong");
  AST_CLEAN_FMT: assert property (o_pkt_valid && !o_pkt_data[23] |->
    o_pkt_data[18:16] inside {3'h1, 3'h2, 3'h5}) else $error("bad clean format");
  AST_SUBTYPE: assert property (o_pkt_valid && !o_pkt_data[23] &&
    o_pkt_data[18:16] == 3'h5 |-> o_pkt_data[3:1] == 3'h2) else $error("subtype sent");
  AST_FIRST_WORD: assert property (i_word_valid && !seen_r[i_word_phase] &&
    !o_pkt_valid |=> !o_pkt_valid) else $error("first word of phase sent");
  AST_CAUSE: assert property ($rose(o_pkt_valid) |-> $past(i_word_valid))
    else $error("packet without a word");
endmodule // biw_packet_props

bind biw_packet_builder biw_packet_props u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_frame_start(i_frame_start),
  .i_word_valid(i_word_valid), .i_word_phase(i_word_phase), .i_word_fmt(i_word_fmt),
  .i_word_info(i_word_info), .i_word_err_cnt(i_word_err_cnt),
  .i_word_chk_fail(i_word_chk_fail), .o_pkt_valid(o_pkt_valid),
  .o_pkt_data(o_pkt_data), .i_pkt_ready(i_pkt_ready));

// file: tb/host_pkt_sink.sv
`timescale 1ns/1ps

// host side: takes packets unless told to stall
module host_pkt_sink (
  input  wire        i_mclk,      // clock
  input  wire        i_rst_n,     // sync reset, active low
  input  wire        i_stall,     // hold off packets
  input  wire        i_pkt_valid, // packet waiting
  input  wire [31:0] i_pkt_data,  // packet bytes
  output reg         o_pkt_ready, // take packet
  output reg  [31:0] o_last,      // last packet taken
  output reg  [7:0]  o_cnt        // packets taken
);
  // unused bits may hold anything, so they are dropped on capture
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pkt_ready <= 1'b0;
      o_last      <= 32'h0000_0000;
      o_cnt       <= 8'h00;
    end else begin
      o_pkt_ready <= !i_stall;
      if (i_pkt_valid && o_pkt_ready) begin
        o_last <= i_pkt_data & 32'hFFE7_3FFF;
        o_cnt  <= o_cnt + 8'h01;
      end
    end
  end
endmodule // host_pkt_sink

// file: tb/time_info_word_packet_builder_tb.sv
`timescale 1ns/1ps
`include "biw_consts.vh"

module time_info_word_packet_builder_tb;
  reg         clk = 1'b0, rst_n = 1'b0, fs = 1'b0, wv = 1'b0, cf = 1'b0, stall = 1'b0;
  reg         awv = 1'b0, wvl = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  reg  [1:0]  ph = 2'h0;
  reg  [2:0]  fmt = 3'h0, ec = 3'h0;
  reg  [13:0] info = 14'h0000;
  reg  [5:0]  awa = 6'h00, ara = 6'h00;
  reg  [31:0] wd = 32'h0000_0000, rd;
  reg  [1:0]  rr;
  reg  [7:0]  cnt0;
  wire        pv, rdy, awr, wr, bv, arr, rv;
  wire [31:0] pd, last, rdata;
  wire [1:0]  bresp, rresp;
  wire [7:0]  cnt;
  int         err_total = 0, comparisons = 0;

  always #12.5 clk = ~clk;

  biw_packet_builder u_dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_frame_start(fs), .i_word_valid(wv),
    .i_word_phase(ph), .i_word_fmt(fmt), .i_word_info(info), .i_word_err_cnt(ec),
    .i_word_chk_fail(cf), .o_pkt_valid(pv), .o_pkt_data(pd), .i_pkt_ready(rdy),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wvl),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  host_pkt_sink u_host (
    .i_mclk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_pkt_valid(pv),
    .i_pkt_data(pd), .o_pkt_ready(rdy), .o_last(last), .o_cnt(cnt));

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task finish_test;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task tmo(input int n);
    if (n >= 60) begin
      err_total++;
      $display("ERROR wait expected answer seen none");
      finish_test;
    end
  endtask

  function [31:0] pk(input e, input [1:0] p, input [2:0] f, input [13:0] s);
    pk = {`PKT_ID, e, p, 2'b00, f, 2'b00, s};
  endfunction

  task frame;
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
  endtask

  // one-cycle word strobe; the count before it is kept for the checks
  task word(input [1:0] p, input [2:0] f, input [13:0] s, input [2:0] e, input c);
    @(posedge clk);
    cnt0 = cnt;
    wv <= 1'b1; ph <= p; fmt <= f; info <= s; ec <= e; cf <= c;
    @(posedge clk) wv <= 1'b0;
  endtask

  task pkt(input [31:0] exp);
    int n;
    n = 0;
    while (cnt == cnt0 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    tmo(n);
    chk("packet", last, exp & 32'hFFE7_3FFF);
  endtask

  task none;
    repeat (4) @(posedge clk);
    #1 chk("packet count", {24'h0, cnt}, {24'h0, cnt0});
  endtask

  task fwd(input [1:0] p, input [2:0] f, input [13:0] s, input [2:0] e, input c, input x);
    word(p, f, s, e, c);
    pkt(pk(x, p, f, s));
  endtask

  // address and data offered together, bready held from the start
  task axi_wr(input [5:0] a, input [31:0] d);
    int n;
    reg bd;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wvl <= 1'b1; wd <= d; bry <= 1'b1; bd = 0; n = 0;
    while (!bd && n < 60) begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wvl <= 1'b0;
      if (bv) begin
        bry <= 1'b0;
        rr = bresp;
        bd = 1;
      end
    end
    tmo(n);
  endtask

  task axi_rd(input [5:0] a);
    int n;
    reg dn;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1; dn = 0; n = 0;
    while (!dn && n < 60) begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
      if (rv) begin
        rry <= 1'b0; rd = rdata; rr = rresp; dn = 1;
      end
    end
    tmo(n);
  endtask

  task t_reset;
    chk("pkt valid", {31'h0, pv}, 32'h0000_0000);
    axi_rd(`REG_CTRL_OFS);
    chk("ctrl", rd, 32'h0000_0000);
    frame;
    word(2'h0, 3'h1, 14'h3000, 3'h0, 1'b0);
    word(2'h0, 3'h1, 14'h3000, 3'h0, 1'b0);
    none;
    $display("test reset and disabled done");
  endtask

  task t_formats;
    axi_wr(`REG_CTRL_OFS, 32'h0000_0001);
    chk("ctrl resp", {30'h0, rr}, {30'h0, `RESP_OKAY});
    axi_rd(`REG_CTRL_OFS);
    chk("ctrl", rd, 32'h0000_0001);
    frame;
    word(2'h0, 3'h1, 14'h1234, 3'h0, 1'b0);
    none;
    fwd(2'h0, 3'h1, {4'hC, 5'h1F, 5'h1F}, 3'h0, 1'b0, 1'b0);
    fwd(2'h0, 3'h1, {4'h1, 5'h01, 5'h00}, 3'h0, 1'b0, 1'b0);
    fwd(2'h0, 3'h2, {3'h7, 6'h3B, 5'h17}, 3'h0, 1'b0, 1'b0);
    word(2'h0, 3'h3, {3'h4, 6'h1E, 5'h0C}, 3'h0, 1'b0);
    pkt(pk(1'b0, 2'h0, 3'h2, {3'h4, 6'h1E, 5'h0C}));
    fwd(2'h0, 3'h5, {3'h5, 1'b0, 1'b1, 5'h13, 4'h4}, 3'h0, 1'b0, 1'b0);
    fwd(2'h0, 3'h5, {3'h2, 1'b0, 1'b0, 5'h1F, 4'h5}, 3'h0, 1'b0, 1'b0);
    $display("test formats done");
  endtask

  task t_suppress;
    word(2'h0, 3'h5, {10'h155, 4'h6}, 3'h0, 1'b0);
    none;
    word(2'h0, 3'h4, 14'h0AAA, 3'h0, 1'b0);
    none;
    fwd(2'h0, 3'h4, 14'h0AAA, 3'h3, 1'b0, 1'b1);
    fwd(2'h0, 3'h7, 14'h1555, 3'h0, 1'b1, 1'b1);
    fwd(2'h0, 3'h3, 14'h0123, 3'h4, 1'b0, 1'b1);
    fwd(2'h0, 3'h1, {4'h6, 5'h0F, 5'h03}, 3'h2, 1'b0, 1'b0);
    $display("test suppress done");
  endtask

  task t_phases;
    for (int p = 1; p < 4; p++) begin
      word(2'(p), 3'h1, 14'h2222, 3'h0, 1'b0);
      none;
      fwd(2'(p), 3'h1, {4'h2, 5'h0A, 5'h05}, 3'h0, 1'b0, 1'b0);
    end
    frame;
    word(2'h0, 3'h1, 14'h2222, 3'h0, 1'b0);
    none;
    $display("test phases done");
  endtask

  // host stalls: the second word is dropped and flagged
  task t_stall;
    @(posedge clk) stall <= 1'b1;
    word(2'h0, 3'h2, 14'h0123, 3'h0, 1'b0);
    word(2'h0, 3'h2, 14'h0456, 3'h0, 1'b0);
    axi_rd(`REG_STATUS_OFS);
    chk("status", rd & 32'h0000_0003, 32'h0000_0003);
    @(posedge clk) stall <= 1'b0;
    pkt(pk(1'b0, 2'h0, 3'h2, 14'h0123));
    cnt0 = cnt;
    none;
    axi_wr(`REG_STATUS_OFS, 32'h0000_0002);
    axi_rd(`REG_STATUS_OFS);
    chk("status clear", rd & 32'h0000_0003, 32'h0000_0000);
    axi_rd(6'h3C);
    chk("unmapped resp", {30'h0, rr}, {30'h0, `RESP_SLVERR});
    chk("unmapped data", rd, 32'h0000_0000);
    axi_rd(`REG_DATE_OFS);
    chk("date view", rd, 32'h0000_0945);
    axi_rd(`REG_ZONE_OFS);
    chk("zone view", rd, 32'h0000_11F5);
    $display("test stall done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_formats;
    t_suppress;
    t_phases;
    t_stall;
    finish_test;
  end

  // guard against a hang anywhere
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("ERROR run expected end seen none");
    finish_test;
  end
endmodule // time_info_word_packet_builder_tb
